// [logic/timer_counter_defines.vh]
// Constants for the sixteen bit timer/counter block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
`ifndef TIMER_COUNTER_DEFINES_VH
`define TIMER_COUNTER_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_COUNT_LOW      5'h00
`define ADDR_COUNT_HIGH     5'h04
`define ADDR_CONTROL        5'h08
`define ADDR_FLAGS          5'h0c
`define ADDR_ENABLES        5'h10
`define ADDR_OTHER_CONTROL  5'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_RUN_BIT         0
`define CTL_SRC_BIT         1
`define CTL_NOSYNC_BIT      2
`define CTL_ASSIGN_LO_BIT   3
`define CTL_PS_LO_BIT       4
`define CTL_PS_HI_BIT       5
`define CTL_ASSIGN_HI_BIT   6
`define CTL_WIDE_BIT        7
`define CTL_RESET           8'h00

// ----------------------------------------------------------------
// Flag, enable and oscillator fields
// ----------------------------------------------------------------
`define OVF_FLAG_BIT        1
`define OVF_ENABLE_BIT      1
`define OSC_ENABLE_BIT      3

// ----------------------------------------------------------------
// Codes and values
// ----------------------------------------------------------------
`define SPECIAL_EVENT_CODE  4'hb
`define COUNT_ALL_ONES      16'hffff
`define COUNT_ZERO          16'h0000
`define PS_DIV1             2'h0
`define PS_DIV2             2'h1
`define PS_DIV4             2'h2
`define PS_LIMIT_DIV1       3'h0
`define PS_LIMIT_DIV2       3'h1
`define PS_LIMIT_DIV4       3'h3
`define PS_LIMIT_DIV8       3'h7
`define INSTR_DIV_DEFAULT   4

`endif

// [logic/clock_edge_detect.v]
// Edge detector for the external count input.
// Assumes the raw input is already synchronous to clock.
`timescale 1ns/1ps
`default_nettype none

module clock_edge_detect (
    input  wire clock,
    input  wire rstN,
    input  wire rawIn,
    input  wire bypassSync,
    input  wire enable,
    output wire risePulse
);

    reg  syncA_r;
    reg  syncB_r;
    reg  prev_r;
    reg  armed_r;
    wire level;

    // ------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------
    assign level = bypassSync ? rawIn : syncB_r;

    always @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            syncA_r <= 1'b0;
            syncB_r <= 1'b0;
            prev_r  <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            syncA_r <= rawIn;
            syncB_r <= syncA_r;
            prev_r  <= level;
            // First rise only counts after a fall was seen
            if (!enable)
                armed_r <= 1'b0;
            else if (prev_r && !level)
                armed_r <= 1'b1;
        end
    end

    assign risePulse = enable & armed_r & ~prev_r & level;

endmodule // clock_edge_detect

`default_nettype wire

// [logic/sixteen_bit_timer_counter.v]
// Sixteen bit up timer/counter with buffered wide access.
// Assumes an Avalon-MM master and pins synchronous to clock.
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_defines.vh"

module sixteen_bit_timer_counter #(
    parameter INSTR_DIV = `INSTR_DIV_DEFAULT
) (
    input  wire        clock,
    input  wire        nrst,
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [3:0]  byteenable,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    input  wire [1:0]  portCPinLevel,
    input  wire [1:0]  portCDirection,
    input  wire [1:0]  portCOutData,
    output reg  [1:0]  portCPinOut,
    output reg  [1:0]  portCPinOe,
    output reg  [1:0]  portCReadData,
    input  wire [3:0]  compareOneMode,
    input  wire [3:0]  compareTwoMode,
    input  wire        compareOneMatch,
    input  wire [15:0] compareTwoValue,
    input  wire        adcEnable,
    output reg         adcStart,
    output reg         overflowIrq
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg rstSyncA_r;
    reg rstSyncB_r;
    wire rstN;

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rstSyncA_r <= 1'b0;
            rstSyncB_r <= 1'b0;
        end
        else
        begin
            rstSyncA_r <= 1'b1;
            rstSyncB_r <= rstSyncA_r;
        end
    end

    assign rstN = rstSyncB_r;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg  [15:0] count_r;
    reg  [7:0]  highBuf_r;
    reg  [7:0]  control_r;
    reg         overflowFlag_r;
    reg         overflowEnable_r;
    reg         secOscEnable_r;
    reg  [2:0]  psCount_r;
    reg  [7:0]  instrDiv_r;
    reg  [2:0]  psLimit;
    reg  [31:0] readMux;
    reg  [15:0] count_nxt;
    reg         overflowFlag_nxt;

    wire        runEnable  = control_r[`CTL_RUN_BIT];
    wire        srcSelect  = control_r[`CTL_SRC_BIT];
    wire        noSync     = control_r[`CTL_NOSYNC_BIT];
    wire        wideAccess = control_r[`CTL_WIDE_BIT];
    wire [1:0]  psSelect   = control_r[`CTL_PS_HI_BIT:`CTL_PS_LO_BIT];
    wire        assignHi   = control_r[`CTL_ASSIGN_HI_BIT];
    wire        assignLo   = control_r[`CTL_ASSIGN_LO_BIT];

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Edge one captures read data, edge two commits the access
    // Costs a wait state but keeps readdata straight from a flop
    wire req     = read | write;
    wire accept  = req & waitrequest;
    wire commit  = req & ~waitrequest;
    wire wrLane  = commit & write & byteenable[0];
    wire wrLow   = wrLane && (address == `ADDR_COUNT_LOW);
    wire wrHigh  = wrLane && (address == `ADDR_COUNT_HIGH);
    wire wrCtl   = wrLane && (address == `ADDR_CONTROL);
    wire wrFlag  = wrLane && (address == `ADDR_FLAGS);
    wire wrEn    = wrLane && (address == `ADDR_ENABLES);
    wire wrOsc   = wrLane && (address == `ADDR_OTHER_CONTROL);
    wire rdLow   = accept && read && (address == `ADDR_COUNT_LOW);
    wire countWrite = wrLow | (wrHigh & ~wideAccess);

    always @*
    begin
        readMux = 32'h0000_0000;
        if (address == `ADDR_COUNT_LOW)
            readMux[7:0] = count_r[7:0];
        else if (address == `ADDR_COUNT_HIGH)
            readMux[7:0] = wideAccess ? highBuf_r : count_r[15:8];
        else if (address == `ADDR_CONTROL)
            readMux[7:0] = control_r;
        else if (address == `ADDR_FLAGS)
            readMux[`OVF_FLAG_BIT] = overflowFlag_r;
        else if (address == `ADDR_ENABLES)
            readMux[`OVF_ENABLE_BIT] = overflowEnable_r;
        else if (address == `ADDR_OTHER_CONTROL)
            readMux[`OSC_ENABLE_BIT] = secOscEnable_r;
    end

    always @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end
        else
        begin
            if (commit)
                waitrequest <= 1'b1;
            else if (req)
                waitrequest <= 1'b0;
            if (accept && read)
                readdata <= readMux;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            control_r        <= `CTL_RESET;
            overflowEnable_r <= 1'b0;
            secOscEnable_r   <= 1'b0;
            highBuf_r        <= 8'h00;
        end
        else
        begin
            if (wrCtl)
                control_r <= writedata[7:0];
            if (wrEn)
                overflowEnable_r <= writedata[`OVF_ENABLE_BIT];
            if (wrOsc)
                secOscEnable_r <= writedata[`OSC_ENABLE_BIT];
            if (rdLow && wideAccess)
                highBuf_r <= count_r[15:8];
            else if (wrHigh && wideAccess)
                highBuf_r <= writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Clock source and prescaler
    // ------------------------------------------------------------
    wire extRaw  = secOscEnable_r ? portCPinLevel[1] : portCPinLevel[0];
    wire extRise;
    wire instrTick = (instrDiv_r == INSTR_DIV - 1);
    wire srcTick   = srcSelect ? extRise : instrTick;
    wire psWrap    = (psCount_r == psLimit);
    wire countTick = runEnable & srcTick & psWrap;

    clock_edge_detect edgeDetect (
        .clock      (clock),
        .rstN       (rstN),
        .rawIn      (extRaw),
        .bypassSync (noSync),
        .enable     (srcSelect),
        .risePulse  (extRise)
    );

    always @*
    begin
        case (psSelect)
            `PS_DIV1: psLimit = `PS_LIMIT_DIV1;
            `PS_DIV2: psLimit = `PS_LIMIT_DIV2;
            `PS_DIV4: psLimit = `PS_LIMIT_DIV4;
            default:  psLimit = `PS_LIMIT_DIV8;
        endcase
    end

    always @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            instrDiv_r <= 8'h00;
            psCount_r  <= 3'h0;
        end
        else
        begin
            // Free running, so starting the counter never shifts the phase
            if (instrTick)
                instrDiv_r <= 8'h00;
            else
                instrDiv_r <= instrDiv_r + 8'h01;
            if (wrLow)
                psCount_r <= 3'h0;
            else if (runEnable && srcTick)
                psCount_r <= psWrap ? 3'h0 : psCount_r + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Special event trigger
    // ------------------------------------------------------------
    // Unit one uses this counter only when the high assign bit is set
    wire oneUsesUs = assignHi;
    wire twoUsesUs = assignHi | assignLo;
    wire eventOne  = compareOneMatch && oneUsesUs && (compareOneMode == `SPECIAL_EVENT_CODE);
    wire eventTwo  = (count_r == compareTwoValue) && twoUsesUs
                     && (compareTwoMode == `SPECIAL_EVENT_CODE);
    wire specialEvent = eventOne | eventTwo;

    // ------------------------------------------------------------
    // Counter and overflow
    // ------------------------------------------------------------
    wire wrapNow = countTick && !countWrite && !specialEvent && (count_r == `COUNT_ALL_ONES);

    always @*
    begin
        count_nxt = count_r;
        // Software write beats the event reset
        if (wrLow)
            count_nxt = {(wideAccess ? highBuf_r : count_r[15:8]), writedata[7:0]};
        else if (wrHigh && !wideAccess)
            count_nxt[15:8] = writedata[7:0];
        else if (specialEvent)
            count_nxt = `COUNT_ZERO;
        else if (countTick)
            count_nxt = count_r + 16'h0001;
    end

    always @*
    begin
        overflowFlag_nxt = overflowFlag_r;
        // Hardware set wins over a software clear
        if (wrapNow)
            overflowFlag_nxt = 1'b1;
        else if (wrFlag)
            overflowFlag_nxt = writedata[`OVF_FLAG_BIT];
    end

    always @(posedge clock or negedge rstN)
    begin
        if (!rstN)
            count_r <= `COUNT_ZERO;
        else
            count_r <= count_nxt;
    end

    always @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            overflowFlag_r <= 1'b0;
            overflowIrq    <= 1'b0;
            adcStart       <= 1'b0;
        end
        else
        begin
            overflowFlag_r <= overflowFlag_nxt;
            overflowIrq    <= overflowFlag_r & overflowEnable_r;
            adcStart    <= eventTwo & adcEnable;
        end
    end

    // ------------------------------------------------------------
    // Shared port pins
    // ------------------------------------------------------------
    // Direction bits of 1 mean input; the oscillator overrides them
    localparam PIN_COUNT = 2;
    genvar pin;

    generate
        for (pin = 0; pin < PIN_COUNT; pin = pin + 1)
        begin : pinSlice
            always @(posedge clock or negedge rstN)
            begin
                if (!rstN)
                begin
                    portCPinOut[pin]   <= 1'b0;
                    portCPinOe[pin]    <= 1'b0;
                    portCReadData[pin] <= 1'b0;
                end
                else
                begin
                    portCPinOut[pin]   <= portCOutData[pin];
                    portCPinOe[pin]    <= ~secOscEnable_r & ~portCDirection[pin];
                    portCReadData[pin] <= ~secOscEnable_r & portCPinLevel[pin];
                end
            end
        end
    endgenerate

endmodule // sixteen_bit_timer_counter

`default_nettype wire

// [testbench/tc_checker.sv]
// Port-level assertions for the timer/counter.
// Assumes a bind onto sixteen_bit_timer_counter.
`timescale 1ns/1ps
`default_nettype none
module tc_checker (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [4:0]  address,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata,
    input wire logic        waitrequest,
    input wire logic [1:0]  portCPinLevel,
    input wire logic [1:0]  portCDirection,
    input wire logic [1:0]  portCPinOe,
    input wire logic [1:0]  portCReadData,
    input wire logic [3:0]  compareTwoMode,
    input wire logic        adcEnable,
    input wire logic        adcStart,
    input wire logic        overflowIrq
);
    // --------------------------------
    // Register shadows
    // --------------------------------
    // Internal reset lags nrst, so checks wait four edges
    logic [3:0] up_r;
    logic [7:0] ctl_r;
    logic       oscEn_r;
    logic       irqEn_r;
    wire        wrHit = write && !waitrequest && byteenable[0];
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            up_r <= 4'h0;
            ctl_r <= 8'h00;
            oscEn_r <= 1'b0;
            irqEn_r <= 1'b0;
        end
        else
        begin
            up_r <= {up_r[2:0], 1'b1};
            if (wrHit && address == 5'h08)
                ctl_r <= writedata[7:0];
            if (wrHit && address == 5'h14)
                oscEn_r <= writedata[3];
            if (wrHit && address == 5'h10)
                irqEn_r <= writedata[1];
        end
    end
    // --------------------------------
    // Assertions
    // --------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!up_r[3]);
    a_osc_pins_input: assert property ($past(oscEn_r) |-> portCPinOe == 2'h0)
        else $error("pin driven while oscillator on");
    a_oe_from_dir: assert property (!$past(oscEn_r) |-> portCPinOe == ~$past(portCDirection))
        else $error("pin enable does not follow direction");
    a_osc_reads_zero: assert property ($past(oscEn_r) |-> portCReadData == 2'h0)
        else $error("pin read not zero with oscillator on");
    a_read_from_pin: assert property (!$past(oscEn_r) |-> portCReadData == $past(portCPinLevel))
        else $error("pin read does not follow level");
    a_irq_needs_enable: assert property (overflowIrq |-> $past(irqEn_r))
        else $error("interrupt without enable");
    a_irq_stays_latched: assert property (overflowIrq && !write && !$past(write) |=> overflowIrq)
        else $error("interrupt dropped without a write");
    a_adc_needs_cause: assert property (adcStart |-> $past(adcEnable) && $past(compareTwoMode) == 4'hb)
        else $error("conversion start without cause");
    a_adc_needs_assign: assert property (adcStart |-> $past(ctl_r[6]) || $past(ctl_r[3]))
        else $error("conversion start with unit two unassigned");
endmodule // tc_checker
bind sixteen_bit_timer_counter tc_checker chk (.clock(clock), .nrst(nrst), .address(address),
    .write(write), .byteenable(byteenable), .writedata(writedata), .waitrequest(waitrequest),
    .portCPinLevel(portCPinLevel), .portCDirection(portCDirection), .portCPinOe(portCPinOe),
    .portCReadData(portCReadData), .compareTwoMode(compareTwoMode), .adcEnable(adcEnable),
    .adcStart(adcStart), .overflowIrq(overflowIrq));
`default_nettype wire

// [testbench/ext_clock_source.sv]
// External clock pin and oscillator model.
// Assumes bursts are started right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
    input  wire logic       clock,
    output var  logic [1:0] pinLevel
);
    // Idles high so each burst opens with a fall
    initial pinLevel = 2'b11;
    task automatic burst(input int n);
        repeat (n)
        begin
            pinLevel <= 2'b00;
            repeat (2) @(posedge clock);
            pinLevel <= 2'b11;
            repeat (2) @(posedge clock);
        end
    endtask
endmodule // ext_clock_source
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the timer/counter.
// Assumes the bound checker and the clock source model.
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module testbench;
    localparam logic [4:0] LO = `ADDR_COUNT_LOW, HI = `ADDR_COUNT_HIGH, CT = `ADDR_CONTROL;
    localparam logic [4:0] FL = `ADDR_FLAGS, EN = `ADDR_ENABLES, OC = `ADDR_OTHER_CONTROL;
    logic        clock = 0, nrst = 0, read = 0, write = 0, compareOneMatch = 0, adcEnable = 0;
    logic [4:0]  address = 0;
    logic [31:0] writedata = 0, rdVal;
    logic [3:0]  compareTwoMode = 0, compareOneMode = 4'hb;
    logic [15:0] compareTwoValue = 0;
    wire  [31:0] readdata;
    wire         waitrequest, adcStart, overflowIrq;
    wire  [1:0]  pinLevel, portCPinOut, portCPinOe, portCReadData;
    int          n_mismatch = 0, n_tests = 0, nAdc = 0, i;
    always #4 clock = ~clock;
    always @(posedge clock) if (adcStart) nAdc++;
    ext_clock_source ext (.clock, .pinLevel);
    sixteen_bit_timer_counter uut (.clock, .nrst, .address, .read, .write, .byteenable(4'h1),
        .writedata, .readdata, .waitrequest, .portCPinLevel(pinLevel), .portCDirection(2'h1),
        .portCOutData(2'h2), .portCPinOut, .portCPinOe, .portCReadData, .compareOneMode,
        .compareTwoMode, .compareOneMatch, .compareTwoValue, .adcEnable, .adcStart, .overflowIrq);
    // --------------------------------
    // Bus tasks
    // --------------------------------
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        int t;
        t = 0;
        // Back to back: let the release of the last access reach an edge
        if (read || write)
            @(posedge clock);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= {24'h0, d};
        @(posedge clock);
        while (waitrequest && t < 100)
        begin
            @(posedge clock);
            t++;
        end
        if (t == 100) n_mismatch++;
        rdVal = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        `CHK(rdVal, {24'h0, e})
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #(20000 * 8);
        n_mismatch++;
        summarize();
    end
    // --------------------------------
    // Scenarios
    // --------------------------------
    initial
    begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        for (i = 0; i < 7; i++) rdc(5'(i * 4), 8'h00);
        for (i = 0; i < 4; i++)
        begin
            wr(HI, 8'h00);
            wr(LO, 8'h00);
            wr(CT, 8'(8'h01 | (i << 4)));
            repeat (64) @(posedge clock);
            wr(CT, 8'h00);
            acc(1'b0, LO, 8'h00);
            `CHK(rdVal[7:0] >= (16 >> i) - 1 && rdVal[7:0] <= (16 >> i) + 1, 1'b1)
        end
        repeat (20) @(posedge clock);
        rdc(LO, rdVal[7:0]);
        wr(HI, 8'h56);
        wr(LO, 8'h78);
        wr(CT, 8'h80);
        wr(HI, 8'h12);
        rdc(HI, 8'h12);
        wr(CT, 8'h00);
        rdc(HI, 8'h56);
        wr(CT, 8'h80);
        wr(LO, 8'h34);
        wr(HI, 8'haa);
        rdc(LO, 8'h34);
        rdc(HI, 8'h12);
        wr(CT, 8'h00);
        rdc(HI, 8'h12);
        wr(HI, 8'hff);
        wr(LO, 8'hfd);
        wr(CT, 8'h01);
        repeat (40) @(posedge clock);
        wr(CT, 8'h00);
        `CHK(overflowIrq, 1'b0)
        rdc(FL, 8'h02);
        rdc(HI, 8'h00);
        wr(EN, 8'h02);
        repeat (2) @(posedge clock);
        `CHK(overflowIrq, 1'b1)
        wr(FL, 8'h00);
        repeat (2) @(posedge clock);
        `CHK(overflowIrq, 1'b0)
        wr(LO, 8'h00);
        compareTwoMode <= 4'hb;
        compareTwoValue <= 16'h0005;
        adcEnable <= 1'b1;
        wr(CT, 8'h09);
        repeat (200) @(posedge clock);
        wr(CT, 8'h00);
        `CHK(nAdc > 2, 1'b1)
        acc(1'b0, LO, 8'h00);
        `CHK(rdVal[7:0] <= 8'h05, 1'b1)
        rdc(FL, 8'h00);
        compareTwoValue <= 16'hffff;
        wr(HI, 8'hff);
        wr(LO, 8'hfd);
        wr(CT, 8'h09);
        repeat (40) @(posedge clock);
        wr(CT, 8'h00);
        rdc(FL, 8'h00);
        rdc(HI, 8'h00);
        compareTwoMode <= 4'h0;
        wr(LO, 8'h40);
        wr(CT, 8'h40);
        compareOneMatch <= 1'b1;
        @(posedge clock);
        compareOneMatch <= 1'b0;
        rdc(LO, 8'h00);
        wr(LO, 8'h40);
        compareOneMode <= 4'ha;
        compareOneMatch <= 1'b1;
        @(posedge clock);
        compareOneMatch <= 1'b0;
        compareOneMode <= 4'hb;
        rdc(LO, 8'h40);
        compareOneMatch <= 1'b1;
        wr(LO, 8'h22);
        compareOneMatch <= 1'b0;
        rdc(LO, 8'h22);
        for (i = 0; i < 3; i++)
        begin
            wr(OC, i == 2 ? 8'h08 : 8'h00);
            wr(LO, 8'h00);
            wr(CT, i == 1 ? 8'h07 : 8'h03);
            ext.burst(8);
            repeat (6) @(posedge clock);
            wr(CT, 8'h00);
            rdc(LO, 8'h08);
        end
        `CHK(portCPinOe, 2'h0)
        `CHK(portCReadData, 2'h0)
        `CHK(portCPinOut, 2'h2)
        summarize();
    end
endmodule // testbench
`default_nettype wire
